// ---- logic/timebase_select_pkg.sv ----
// constants shared by the timebase selection block
package timebase_select_pkg;
   // register byte offsets on the AXI4-Lite bus
   localparam logic [3:0] OFFSET_SELECT_FIRST = 4'h0;
   localparam logic [3:0] OFFSET_SELECT_SECOND = 4'h4;
   localparam logic [3:0] OFFSET_MODE_BASE = 4'h8;
   // field positions, low bit of each two-bit field
   localparam int FIELD_UNIT_ONE = 0;
   localparam int FIELD_UNIT_TWO = 2;
   localparam int FIELD_UNIT_THREE = 4;
   localparam int FIELD_UNIT_FOUR = 6;
   localparam int FIELD_UNIT_FIVE = 0;
   localparam int FIELD_PWM_SIX = 2;
   localparam int FIELD_PWM_SEVEN = 4;
   // reset values: every field loads 01
   localparam logic [7:0] RESET_SELECT_FIRST = 8'h55;
   localparam logic [7:0] RESET_SELECT_SECOND = 8'h15;
   // implemented bits of the second register
   localparam logic [7:0] MASK_SELECT_SECOND = 8'h3F;
   // selection codes
   localparam logic [1:0] CHOICE_RESERVED = 2'h0;
   localparam logic [1:0] CHOICE_PAIR_ONE = 2'h1;
   localparam logic [1:0] CHOICE_PAIR_TWO = 2'h2;
   localparam logic [1:0] CHOICE_PAIR_THREE = 2'h3;
   // unit mode codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_PWM = 4'hF;
   localparam logic [3:0] MODE_CAPTURE_LOW = 4'h3;
   localparam logic [3:0] MODE_CAPTURE_HIGH = 4'h7;
   localparam logic [3:0] MODE_COMPARE_A = 4'h1;
   localparam logic [3:0] MODE_COMPARE_B = 4'h2;
   localparam logic [3:0] MODE_COMPARE_LOW = 4'h8;
   localparam logic [3:0] MODE_COMPARE_HIGH = 4'hB;
   // timer numbering on the three-bit timer outputs, zero for none
   localparam int TIMER_COUNT = 6;
   localparam logic [2:0] TIMER_NONE = 3'h0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // unit counts
   localparam int CAPTURE_UNITS = 5;
   localparam int PULSE_UNITS = 2;
endpackage : timebase_select_pkg

// ---- logic/timebase_route.sv ----
// decode of one unit's selection field and mode into a timer number
`timescale 1ns/1ps
module timebase_route (
   // configuration
   input wire logic [1:0] choice,
   input wire logic [3:0] mode,
   input wire logic pulseOnly,
   // result: timer number 1..6, zero for none
   output logic [2:0] timerNumber,
   output logic timerValid
);
   // classification of the mode field
   wire logic isPwm;
   wire logic isCapture;
   wire logic isCompare;
   wire logic useEven;
   wire logic [2:0] oddTimer;
   // pulse-only units always run the pwm timer and ignore mode
   assign isPwm = pulseOnly | (mode == timebase_select_pkg::MODE_PWM);
   assign isCapture = (mode >= timebase_select_pkg::MODE_CAPTURE_LOW)
      && (mode <= timebase_select_pkg::MODE_CAPTURE_HIGH);
   assign isCompare = (mode == timebase_select_pkg::MODE_COMPARE_A)
      || (mode == timebase_select_pkg::MODE_COMPARE_B)
      || ((mode >= timebase_select_pkg::MODE_COMPARE_LOW)
      && (mode <= timebase_select_pkg::MODE_COMPARE_HIGH));
   assign useEven = isPwm;
   // odd timer of the pair: 01->1, 10->3, 11->5
   assign oddTimer = {choice, 1'b0} - 3'h1;
   // reserved choice, off or reserved mode selects nothing
   assign timerValid = (choice != timebase_select_pkg::CHOICE_RESERVED)
      && (isPwm || isCapture || isCompare);
   assign timerNumber = !timerValid ? timebase_select_pkg::TIMER_NONE
      : (useEven ? oddTimer + 3'h1 : oddTimer);
endmodule : timebase_route

// ---- logic/capture_pwm_timebase_select.sv ----
// AXI4-Lite register block routing timers to capture and pulse units
`timescale 1ns/1ps
// How it works
// - unit four field bits 7-6 picks pair
// - unit three field bits 5-4 picks pair
// - unit two field bits 3-2 picks pair
// - unit one field bits 1-0 picks pair
// - odd timer for capture/compare, even for pwm
// - every field resets to 01
// - pulse six field bits 3-2 picks timer
// - second register bits 7-6 read zero
// - mode field selects which pair timer used
module capture_pwm_timebase_select #(
   parameter int ADDR_WIDTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // AXI4-Lite write address
   input wire logic [ADDR_WIDTH-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [ADDR_WIDTH-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // unit mode fields, packed four bits per capture unit
   input wire logic [19:0] unitModes,
   // timer number feeding each unit, three bits each, zero for none
   output logic [14:0] captureTimer,
   output logic [5:0] pulseTimer
);
   // selection registers
   logic [7:0] unitTimerSelectFirst;
   logic [7:0] unitTimerSelectSecond;
   // captured write address and data
   logic [ADDR_WIDTH-1:0] writeAddr;
   logic writeAddrHeld;
   logic [31:0] writeData;
   logic [3:0] writeStrb;
   logic writeDataHeld;
   // named field views
   wire logic [1:0] unit_one_timer_choice;
   wire logic [1:0] unit_two_timer_choice;
   wire logic [1:0] unit_three_timer_choice;
   wire logic [1:0] unit_four_timer_choice;
   wire logic [1:0] unit_five_timer_choice;
   wire logic [1:0] pwm_six_timer_choice;
   wire logic [1:0] pwm_seven_timer_choice;
   wire logic [9:0] captureChoices;
   wire logic [3:0] pulseChoices;
   assign unit_one_timer_choice = unitTimerSelectFirst[timebase_select_pkg::FIELD_UNIT_ONE +: 2];
   assign unit_two_timer_choice = unitTimerSelectFirst[timebase_select_pkg::FIELD_UNIT_TWO +: 2];
   assign unit_three_timer_choice = unitTimerSelectFirst[timebase_select_pkg::FIELD_UNIT_THREE +: 2];
   assign unit_four_timer_choice = unitTimerSelectFirst[timebase_select_pkg::FIELD_UNIT_FOUR +: 2];
   assign unit_five_timer_choice = unitTimerSelectSecond[timebase_select_pkg::FIELD_UNIT_FIVE +: 2];
   assign pwm_six_timer_choice = unitTimerSelectSecond[timebase_select_pkg::FIELD_PWM_SIX +: 2];
   assign pwm_seven_timer_choice = unitTimerSelectSecond[timebase_select_pkg::FIELD_PWM_SEVEN +: 2];
   assign captureChoices = {unit_five_timer_choice, unit_four_timer_choice, unit_three_timer_choice,
      unit_two_timer_choice, unit_one_timer_choice};
   assign pulseChoices = {pwm_seven_timer_choice, pwm_six_timer_choice};

   // address decode, a function because reads and writes share it
   function automatic logic [1:0] decode_reg(input logic [ADDR_WIDTH-1:0] addr);
      decode_reg = 2'h0;
      if (addr == timebase_select_pkg::OFFSET_SELECT_FIRST[ADDR_WIDTH-1:0]) begin
         decode_reg = 2'h1;
      end else if (addr == timebase_select_pkg::OFFSET_SELECT_SECOND[ADDR_WIDTH-1:0]) begin
         decode_reg = 2'h2;
      end
   endfunction : decode_reg

   // write path: address and data taken in either order, response after both
   wire logic writeFire;
   wire logic [1:0] writeHit;
   wire logic writeLane;
   wire logic [7:0] writeByte;
   assign awready = !writeAddrHeld && !bvalid;
   assign wready = !writeDataHeld && !bvalid;
   assign writeFire = writeAddrHeld && writeDataHeld && !bvalid;
   assign writeHit = decode_reg(writeAddr);
   assign writeLane = writeStrb[0];
   assign writeByte = writeData[7:0];

   // hold write address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         writeAddr <= '0;
         writeAddrHeld <= 1'b0;
      end else if (awvalid && awready) begin
         writeAddr <= awaddr;
         writeAddrHeld <= 1'b1;
      end else if (writeFire) begin
         writeAddrHeld <= 1'b0;
      end
   end

   // hold write data and strobes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         writeData <= '0;
         writeStrb <= '0;
         writeDataHeld <= 1'b0;
      end else if (wvalid && wready) begin
         writeData <= wdata;
         writeStrb <= wstrb;
         writeDataHeld <= 1'b1;
      end else if (writeFire) begin
         writeDataHeld <= 1'b0;
      end
   end

   // selection registers; a write with byte lane 0 off leaves them alone
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         unitTimerSelectFirst <= timebase_select_pkg::RESET_SELECT_FIRST;
         unitTimerSelectSecond <= timebase_select_pkg::RESET_SELECT_SECOND;
      end else if (writeFire && writeLane) begin
         if (writeHit == 2'h1) begin
            unitTimerSelectFirst <= writeByte;
         end
         if (writeHit == 2'h2) begin
            // top two bits are not stored at all
            unitTimerSelectSecond <= writeByte & timebase_select_pkg::MASK_SELECT_SECOND;
         end
      end
   end

   // write response; unmapped addresses get SLVERR
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bvalid <= 1'b0;
         bresp <= timebase_select_pkg::RESP_OKAY;
      end else if (writeFire) begin
         bvalid <= 1'b1;
         bresp <= (writeHit == 2'h0) ? timebase_select_pkg::RESP_SLVERR : timebase_select_pkg::RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // read path: one cycle from address to data
   wire logic [1:0] readHit;
   wire logic [31:0] readValue;
   assign arready = !rvalid;
   assign readHit = decode_reg(araddr);
   assign readValue = (readHit == 2'h1) ? {24'h000000, unitTimerSelectFirst}
      : (readHit == 2'h2) ? {24'h000000, unitTimerSelectSecond & timebase_select_pkg::MASK_SELECT_SECOND}
      : 32'h00000000;

   // read data register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= timebase_select_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= readValue;
         rresp <= (readHit == 2'h0) ? timebase_select_pkg::RESP_SLVERR : timebase_select_pkg::RESP_OKAY;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // per-unit routing, combinational decode registered onto outputs
   wire logic [14:0] next_captureTimer;
   wire logic [5:0] next_pulseTimer;
   genvar g;
   generate
      for (g = 0; g < timebase_select_pkg::CAPTURE_UNITS; g++) begin : gen_capture
         timebase_route u_route (
            .choice(captureChoices[2*g +: 2]),
            .mode(unitModes[4*g +: 4]),
            .pulseOnly(1'b0),
            .timerNumber(next_captureTimer[3*g +: 3]),
            .timerValid()
         );
      end
      for (g = 0; g < timebase_select_pkg::PULSE_UNITS; g++) begin : gen_pulse
         timebase_route u_route (
            .choice(pulseChoices[2*g +: 2]),
            .mode(timebase_select_pkg::MODE_PWM),
            .pulseOnly(1'b1),
            .timerNumber(next_pulseTimer[3*g +: 3]),
            .timerValid()
         );
      end
   endgenerate

   // outputs from flip-flops, one cycle after config or mode changes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         captureTimer <= '0;
         pulseTimer <= '0;
      end else begin
         captureTimer <= next_captureTimer;
         pulseTimer <= next_pulseTimer;
      end
   end
endmodule : capture_pwm_timebase_select

// ---- dv/timebase_select_monitor.sv ----
// assertion checker for the timebase selection block
`timescale 1ns/1ps
module timebase_select_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // read data
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   // routing
   input wire logic [19:0] unitModes,
   input wire logic [14:0] captureTimer,
   input wire logic [5:0] pulseTimer
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // pulse units never see an odd timer, reserved choice gives zero
   a_pulse_six_even: assert property ($past(resetn) |-> !pulseTimer[0])
      else $error("pulse six got odd timer");
   a_pulse_seven_even: assert property ($past(resetn) |-> !pulseTimer[3])
      else $error("pulse seven got odd timer");
   // one cycle after release both pulse units sit on timer two
   a_reset_default: assert property ($rose(resetn) |=> pulseTimer == 6'h12)
      else $error("pulse units not on default timer");
   // routing lags the mode by one cycle, so compare against the past mode
   a_pwm_even_timer: assert property ($past(resetn) && $past(unitModes[3:0]) == 4'hF |-> !captureTimer[0])
      else $error("pwm unit one got odd timer");
   a_capture_odd: assert property ($past(resetn) && $past(unitModes[7:4]) inside {[4'h3:4'h7]}
      |-> captureTimer[3] || captureTimer[5:3] == 3'h0)
      else $error("capture unit two got even timer");
   a_mode_off_none: assert property ($past(resetn) && $past(unitModes[11:8]) == 4'h0 |-> captureTimer[8:6] == 3'h0)
      else $error("switched off unit three still routed");
   a_compare_odd: assert property ($past(resetn) && $past(unitModes[15:12]) inside {[4'h8:4'hB], 4'h1, 4'h2}
      |-> captureTimer[9] || captureTimer[11:9] == 3'h0)
      else $error("compare unit four got even timer");
   a_reserved_none: assert property ($past(resetn) && $past(unitModes[19:16]) inside {[4'hC:4'hE]}
      |-> captureTimer[14:12] == 3'h0)
      else $error("reserved mode on unit five routed");
   // only one byte per register exists
   a_read_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("read data upper bytes not zero");
endmodule : timebase_select_monitor

bind capture_pwm_timebase_select timebase_select_monitor mon (.clk(clk), .resetn(resetn), .rvalid(rvalid),
   .rdata(rdata), .unitModes(unitModes), .captureTimer(captureTimer), .pulseTimer(pulseTimer));

// ---- dv/unit_core_model.sv ----
// behavioural model of the unit cores presenting their mode fields
`timescale 1ns/1ps
module unit_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // new modes and their load strobe
   input wire logic [19:0] nextModes,
   input wire logic load,
   // modes seen by the selection block
   output logic [19:0] unitModes
);
   // cores wake switched off, so no capture unit is routed until modes are loaded
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         unitModes <= 20'h00000;
      end else if (load) begin
         unitModes <= nextModes;
      end
   end
endmodule : unit_core_model

// ---- dv/capture_pwm_timebase_select_bench.sv ----
// self-checking bench for the timebase selection block
`timescale 1ns/1ps
module capture_pwm_timebase_select_bench;
   // clock, reset and bus drive
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, probe = 1'b0, load = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [19:0] unitModes, em, nextModes = 20'h0;
   logic [14:0] captureTimer;
   logic [5:0] pulseTimer;
   // expected register contents and pending results
   logic [7:0] sel0, sel1;
   // notes carry the response code above the 32-bit value; the watcher owns got, so v stays random
   logic [33:0] expQ[$];
   logic [33:0] got;
   int errorCnt = 0, samplesChecked = 0, cyc = 0, seed = 28227;
   // responses are always accepted at once
   capture_pwm_timebase_select dut (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .unitModes(unitModes), .captureTimer(captureTimer),
      .pulseTimer(pulseTimer));
   unit_core_model cores (.clk(clk), .resetn(resetn), .nextModes(nextModes), .load(load), .unitModes(unitModes));
   initial forever #5 clk = ~clk;
   // expected timer for one field: reserved choice or idle mode gives none
   function automatic logic [2:0] rt(input logic [1:0] c, input logic [3:0] m, input bit p);
      logic [2:0] odd;
      // pair table: 01 -> timers one/two, 10 -> three/four, 11 -> five/six
      odd = (c == 2'h1) ? 3'h1 : (c == 2'h2) ? 3'h3 : 3'h5;
      if (c == 2'h0 || (!p && (m == 4'h0 || m inside {[4'hC:4'hE]}))) return 3'h0;
      return (p || m == 4'hF) ? odd + 3'h1 : odd;
   endfunction : rt
   // expected snapshot of both routing outputs
   function automatic logic [31:0] snap();
      return {11'h0, rt(sel1[1:0], em[19:16], 0), rt(sel0[7:6], em[15:12], 0), rt(sel0[5:4], em[11:8], 0),
         rt(sel0[3:2], em[7:4], 0), rt(sel0[1:0], em[3:0], 0), rt(sel1[5:4], 4'h0, 1), rt(sel1[3:2], 4'h0, 1)};
   endfunction : snap
   task automatic endOfTest();
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : endOfTest
   // watcher: every write response, read beat or routing probe takes the oldest note
   always @(posedge clk) begin
      cyc++;
      if (rvalid || bvalid || probe) begin
         got = probe ? {13'h0, captureTimer, pulseTimer} : bvalid ? {bresp, 32'h0} : {rresp, rdata};
         samplesChecked++;
         if (got !== expQ[0]) begin
            errorCnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, expQ[0]);
         end
         void'(expQ.pop_front());
      end
      if (cyc == 20000) begin
         errorCnt++;
         endOfTest();
      end
   end
   // reset puts every field back on its first pair and switches the cores off
   task automatic rst();
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      sel0 = 8'h55;
      sel1 = 8'h15;
      em = 20'h0;
   endtask : rst
   // write: address and data offered together, each released once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      // only the two selection registers answer OKAY
      expQ.push_back({(a == 4'h0 || a == 4'h4) ? timebase_select_pkg::RESP_OKAY
         : timebase_select_pkg::RESP_SLVERR, 32'h0});
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      fork
         begin
            do @(posedge clk); while (!awready);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge clk); while (!wready);
            wvalid <= 1'b0;
         end
      join
      do @(posedge clk); while (!bvalid);
      if (s[0] && a == 4'h0) sel0 = d[7:0];
      if (s[0] && a == 4'h4) sel1 = {2'h0, d[5:0]};
   endtask : wr
   // read: the note is queued first, the watcher compares the beat
   task automatic rd(input logic [3:0] a);
      expQ.push_back(a == 4'h0 ? {timebase_select_pkg::RESP_OKAY, 24'h0, sel0}
         : a == 4'h4 ? {timebase_select_pkg::RESP_OKAY, 24'h0, sel1}
         : {timebase_select_pkg::RESP_SLVERR, 32'h0});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
   endtask : rd
   // routing settles one cycle after a change, probe after two
   task automatic chk();
      repeat (2) @(posedge clk);
      expQ.push_back({2'h0, snap()});
      probe <= 1'b1;
      @(posedge clk);
      probe <= 1'b0;
   endtask : chk
   initial begin
      rst();
      rd(4'h0);
      rd(4'h4);
      chk();
      for (int i = 0; i < 48; i++) begin
         v = $random(seed);
         nextModes <= v[19:0];
         em = v[19:0];
         load <= 1'b1;
         @(posedge clk);
         load <= 1'b0;
         wr({v[21:20], 2'h0}, $random(seed), v[27:24]);
         rd(4'h0);
         rd(4'h4);
         rd({v[21:20], 2'h0});
         chk();
      end
      rst();
      rd(4'h4);
      chk();
      endOfTest();
   end
endmodule : capture_pwm_timebase_select_bench
